// >>> baud_pkg.sv
// constants, register map and state encoding of the baud generator block
package baud_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [4:0] OFS_TSC = 5'h00;
    localparam logic [4:0] OFS_RSC = 5'h04;
    localparam logic [4:0] OFS_BAUD = 5'h08;
    localparam logic [4:0] OFS_DIV_LO = 5'h0C;
    localparam logic [4:0] OFS_DIV_HI = 5'h10;
    localparam logic [4:0] OFS_RXBUF = 5'h14;
    localparam logic [4:0] OFS_TXBUF = 5'h18;
    localparam logic [4:0] OFS_STAT = 5'h1C;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int TSC_SYNC = 4;
    localparam int TSC_HSPEED = 2;
    localparam int BC_OVF = 7;
    localparam int BC_IDLE = 6;
    localparam int BC_RXINV = 5;
    localparam int BC_TXINV = 4;
    localparam int BC_WIDE = 3;
    localparam int BC_WAKE = 1;
    localparam int BC_ABEN = 0;
    localparam int ST_RXFLAG = 0;

    // ************************************************************
    // reset values and write masks
    // ************************************************************
    localparam logic [7:0] TSC_RST = 8'h02;
    localparam logic [7:0] TSC_WMASK = 8'hFD;
    localparam logic [7:0] RSC_RST = 8'h00;
    localparam logic [7:0] RSC_WMASK = 8'hF8;
    localparam logic [15:0] DIV_RST = 16'h0000;
    localparam logic [15:0] DIV_MAX = 16'hFFFF;

    // ************************************************************
    // timing counts
    // ************************************************************
    localparam logic [9:0] PRE_FAST = 10'h004;
    localparam logic [9:0] PRE_MID = 10'h010;
    localparam logic [9:0] PRE_SLOW = 10'h040;
    localparam int AB_SHIFT = 3;
    localparam logic [2:0] AB_EDGES = 3'h5;
    localparam logic [7:0] SYNC_CHAR = 8'h55;

    typedef enum logic [4:0] {
        AB_IDLE = 5'h01,
        AB_BREAK = 5'h02,
        AB_START = 5'h04,
        AB_RISE = 5'h08,
        AB_COUNT = 5'h10
    } ab_state_t;

endpackage : baud_pkg

// >>> rx_majority.sv
// three-sample majority filter on the receive pin
`timescale 1ns/1ps
`default_nettype none
module rx_majority (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic rx_in, // receive pin, polarity already fixed
    output logic level // filtered level
);

    typedef struct packed {
        logic [2:0] smp;
        logic level;
    } maj_t;

    maj_t st_ff;
    maj_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.smp = {st_ff.smp[1:0], rx_in};
        nxt_st.level = (st_ff.smp[0] & st_ff.smp[1]) |
                       (st_ff.smp[1] & st_ff.smp[2]) |
                       (st_ff.smp[0] & st_ff.smp[2]);
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // preset to the idle level so no false edge follows reset
            st_ff <= '{smp: 3'h7, level: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level = st_ff.level;

    a_majority_vote:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_ff.smp[0] == st_ff.smp[1]) |=> st_ff.level == $past(st_ff.smp[0]))
    else $error("majority filter disagrees with two equal samples");

endmodule : rx_majority
`default_nettype wire

// >>> clk_prescaler.sv
// restartable divider giving a one-cycle enable every div cycles
`timescale 1ns/1ps
`default_nettype none
module clk_prescaler (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic restart, // clear the count, no tick
    input wire logic [9:0] div, // period in clock cycles
    output logic tick // one-cycle enable
);

    typedef struct packed {
        logic [9:0] cnt;
        logic tick;
    } pre_t;

    pre_t st_ff;
    pre_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        if (restart) begin
            nxt_st.cnt = 10'h000;
        // compare with >= so a shorter period takes hold at once
        end else if (st_ff.cnt >= div - 10'h001) begin
            nxt_st.cnt = 10'h000;
            nxt_st.tick = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 10'h001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;

    a_tick_gap:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        st_ff.tick |=> !st_ff.tick [*3])
    else $error("prescaler ticks closer than four cycles");

endmodule : clk_prescaler
`default_nettype wire

// >>> baud_generator_autobaud.sv
// baud generator with auto-baud measurement and Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
module baud_generator_autobaud (
    input wire logic clk_sys, // system clock, 100 MHz
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [4:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall, high by default
    input wire logic rx_pin, // receive pin
    output logic rx_level, // filtered receive level
    output logic baud_tick, // one-cycle pulse per period
    output logic serial_hold, // keeps the serial unit idle
    output logic receive_flag, // set by a finished measurement
    output logic [7:0] tx_data, // byte for the transmitter
    output logic tx_load // one-cycle load of tx_data
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic wait_r;
        logic [7:0] rdata;
        logic [7:0] tsc;
        logic [7:0] rsc;
        logic ovf;
        logic rxinv;
        logic txinv;
        logic wide;
        logic wake;
        logic ab_en;
        logic [15:0] div;
        logic [15:0] bcnt;
        logic baud_tick;
        baud_pkg::ab_state_t ab;
        logic [2:0] rises;
        logic rx_prev;
        logic rx_flag;
        logic hold;
        logic [7:0] tx_data;
        logic tx_load;
    } core_t;

    core_t st_ff;
    core_t nxt_st;
    logic restart;
    logic pre_tick;
    logic [9:0] pdiv;
    logic sync;
    logic rise;
    logic fall;
    logic acc_rd;
    logic acc_wr;
    logic [15:0] lim;
    logic [7:0] wd;

    // measurement divides the generator rate by eight more
    function automatic logic [9:0] pre_div(input logic sy,
                                           input logic wi,
                                           input logic hs,
                                           input logic ms);
        logic [9:0] b;
        if (sy || (wi && hs)) begin
            b = baud_pkg::PRE_FAST;
        end else if (wi || hs) begin
            b = baud_pkg::PRE_MID;
        end else begin
            b = baud_pkg::PRE_SLOW;
        end
        return ms ? (b << baud_pkg::AB_SHIFT) : b;
    endfunction : pre_div

    assign sync = st_ff.tsc[baud_pkg::TSC_SYNC];
    assign pdiv = pre_div(sync, st_ff.wide,
                          st_ff.tsc[baud_pkg::TSC_HSPEED],
                          st_ff.ab != baud_pkg::AB_IDLE);
    assign rise = rx_level && !st_ff.rx_prev;
    assign fall = !rx_level && st_ff.rx_prev;
    assign acc_rd = avs_read && !st_ff.wait_r;
    assign acc_wr = avs_write && !st_ff.wait_r && avs_byteenable[0];
    assign lim = st_ff.wide ? st_ff.div : {8'h00, st_ff.div[7:0]};
    assign wd = avs_writedata[7:0];

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        restart = 1'b0;
        nxt_st.baud_tick = 1'b0;
        nxt_st.tx_load = 1'b0;
        nxt_st.wait_r = 1'b1;
        nxt_st.rx_prev = rx_level;

        // one wait cycle, then the answer stands for one cycle
        if ((avs_read || avs_write) && st_ff.wait_r) begin
            nxt_st.wait_r = 1'b0;
            case (avs_address)
                baud_pkg::OFS_TSC: begin
                    nxt_st.rdata = st_ff.tsc;
                end
                baud_pkg::OFS_RSC: begin
                    nxt_st.rdata = st_ff.rsc;
                end
                baud_pkg::OFS_BAUD: begin
                    nxt_st.rdata = {st_ff.ovf, !st_ff.hold, st_ff.rxinv,
                                    st_ff.txinv, st_ff.wide, 1'b0,
                                    st_ff.wake, st_ff.ab_en};
                end
                baud_pkg::OFS_DIV_LO: begin
                    nxt_st.rdata = st_ff.div[7:0];
                end
                baud_pkg::OFS_DIV_HI: begin
                    nxt_st.rdata = st_ff.div[15:8];
                end
                baud_pkg::OFS_STAT: begin
                    nxt_st.rdata = {7'h00, st_ff.rx_flag};
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end

        // generator: up-counter so a restart is a plain clear
        if (st_ff.ab == baud_pkg::AB_IDLE && pre_tick) begin
            if (st_ff.bcnt >= lim) begin
                nxt_st.bcnt = 16'h0000;
                nxt_st.baud_tick = 1'b1;
            end else begin
                nxt_st.bcnt = st_ff.bcnt + 16'h0001;
            end
        end

        if (acc_rd && avs_address == baud_pkg::OFS_RXBUF) begin
            nxt_st.rx_flag = 1'b0;
        end

        if (acc_wr) begin
            case (avs_address)
                baud_pkg::OFS_TSC: begin
                    nxt_st.tsc = (wd & baud_pkg::TSC_WMASK) |
                                 (baud_pkg::TSC_RST & ~baud_pkg::TSC_WMASK);
                end
                baud_pkg::OFS_RSC: begin
                    nxt_st.rsc = wd & baud_pkg::RSC_WMASK;
                end
                baud_pkg::OFS_BAUD: begin
                    nxt_st.ovf = wd[baud_pkg::BC_OVF];
                    nxt_st.rxinv = wd[baud_pkg::BC_RXINV];
                    nxt_st.txinv = wd[baud_pkg::BC_TXINV];
                    nxt_st.wide = wd[baud_pkg::BC_WIDE];
                    nxt_st.wake = wd[baud_pkg::BC_WAKE];
                    nxt_st.ab_en = wd[baud_pkg::BC_ABEN];
                end
                baud_pkg::OFS_DIV_LO: begin
                    nxt_st.div[7:0] = wd;
                    nxt_st.bcnt = 16'h0000;
                    restart = 1'b1;
                end
                baud_pkg::OFS_DIV_HI: begin
                    nxt_st.div[15:8] = wd;
                    nxt_st.bcnt = 16'h0000;
                    restart = 1'b1;
                end
                baud_pkg::OFS_TXBUF: begin
                    // transmitter shares the clock path, so refuse
                    if (!st_ff.ab_en) begin
                        nxt_st.tx_data = wd;
                        nxt_st.tx_load = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // measurement runs last so its sets win over software
        case (st_ff.ab)
            baud_pkg::AB_IDLE: begin
                if (st_ff.ab_en && !sync) begin
                    nxt_st.div = baud_pkg::DIV_RST;
                    restart = 1'b1;
                    nxt_st.ab = st_ff.wake ? baud_pkg::AB_BREAK
                                           : baud_pkg::AB_START;
                end
            end
            baud_pkg::AB_BREAK: begin
                if (rise) begin
                    nxt_st.wake = 1'b0;
                    nxt_st.ab = baud_pkg::AB_START;
                end
            end
            baud_pkg::AB_START: begin
                if (fall) begin
                    nxt_st.ab = baud_pkg::AB_RISE;
                end
            end
            baud_pkg::AB_RISE: begin
                if (rise) begin
                    nxt_st.rises = 3'h1;
                    nxt_st.ab = baud_pkg::AB_COUNT;
                end
            end
            baud_pkg::AB_COUNT: begin
                if (pre_tick) begin
                    nxt_st.div = st_ff.div + 16'h0001;
                    if (st_ff.div == baud_pkg::DIV_MAX) begin
                        nxt_st.ovf = 1'b1;
                    end
                end
                if (rise) begin
                    nxt_st.rises = st_ff.rises + 3'h1;
                    if (st_ff.rises == baud_pkg::AB_EDGES - 3'h1) begin
                        nxt_st.ab_en = 1'b0;
                        nxt_st.rx_flag = 1'b1;
                        nxt_st.ab = baud_pkg::AB_IDLE;
                    end
                end
            end
            default: begin
                nxt_st.ab = baud_pkg::AB_IDLE;
            end
        endcase

        if (st_ff.ab != baud_pkg::AB_IDLE && (!st_ff.ab_en || sync)) begin
            nxt_st.ab = baud_pkg::AB_IDLE;
        end
        nxt_st.hold = (nxt_st.ab != baud_pkg::AB_IDLE);
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '0;
            st_ff.wait_r <= 1'b1;
            st_ff.tsc <= baud_pkg::TSC_RST;
            st_ff.rsc <= baud_pkg::RSC_RST;
            st_ff.div <= baud_pkg::DIV_RST;
            st_ff.ab <= baud_pkg::AB_IDLE;
            st_ff.rx_prev <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata = {24'h000000, st_ff.rdata};
    assign avs_waitrequest = st_ff.wait_r;
    assign baud_tick = st_ff.baud_tick;
    assign serial_hold = st_ff.hold;
    assign receive_flag = st_ff.rx_flag;
    assign tx_data = st_ff.tx_data;
    assign tx_load = st_ff.tx_load;

    // ************************************************************
    // sampling and prescaling
    // ************************************************************
    rx_majority u_rx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .rx_in(rx_pin ^ st_ff.rxinv),
        .level(rx_level)
    );

    clk_prescaler u_pre (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .restart(restart),
        .div(pdiv),
        .tick(pre_tick)
    );

    // ************************************************************
    // checks
    // ************************************************************
    a_bus_answer:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        ((avs_read || avs_write) && st_ff.wait_r) |=> !st_ff.wait_r ##1
        st_ff.wait_r)
    else $error("bus answer not one cycle after request");

    a_div_cleared:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_ff.ab == baud_pkg::AB_IDLE && st_ff.ab_en && !sync) |=>
        (st_ff.div == 16'h0000 && st_ff.hold))
    else $error("divisor not cleared at measurement start");

    a_fifth_edge:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_ff.ab == baud_pkg::AB_COUNT && rise && st_ff.rises == 3'h4 &&
         st_ff.ab_en && !sync) |=>
        (!st_ff.ab_en && st_ff.rx_flag && !st_ff.hold))
    else $error("fifth edge did not finish the measurement");

    a_count_step:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_ff.ab == baud_pkg::AB_COUNT && pre_tick && st_ff.ab_en &&
         !sync) |=> st_ff.div == $past(st_ff.div) + 16'h0001)
    else $error("divisor pair did not count as 16 bits");

    a_ovf_trap:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_ff.ab == baud_pkg::AB_COUNT && pre_tick && !rise &&
         st_ff.div == 16'hFFFF && st_ff.ab_en && !sync) |=>
        (st_ff.ovf && st_ff.ab_en && st_ff.hold && st_ff.div == 16'h0000))
    else $error("rollover not trapped or measurement stopped");

    a_tick_quiet:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st_ff.hold && $past(st_ff.hold)) |-> !st_ff.baud_tick)
    else $error("generator ticked during measurement");

    a_async_only:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        sync |=> st_ff.ab == baud_pkg::AB_IDLE)
    else $error("measurement active in synchronous mode");

    a_rx_clear:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_rd && avs_address == baud_pkg::OFS_RXBUF &&
         st_ff.ab != baud_pkg::AB_COUNT) |=> !st_ff.rx_flag)
    else $error("receive buffer read left the flag set");

    a_div_restart:
    assert property (@(posedge clk_sys) disable iff (!rst_n)
        (acc_wr && !st_ff.hold && !st_ff.ab_en &&
         (avs_address == baud_pkg::OFS_DIV_LO ||
          avs_address == baud_pkg::OFS_DIV_HI)) |=>
        (st_ff.bcnt == 16'h0000 && !pre_tick))
    else $error("divisor write did not restart the timer");

endmodule : baud_generator_autobaud
`default_nettype wire

// >>> sync_node.sv
// remote node sending the calibration byte, optionally after a break
`timescale 1ns/1ps
`default_nettype none
module sync_node (
    input wire logic clk_sys, // system clock
    input wire logic go, // one-cycle request to send
    input wire logic with_break, // send a break before the byte
    input wire logic [15:0] bit_cycles, // bit time in clock cycles
    output logic line, // serial line, idle high
    output logic busy // frame in progress
);
    logic [9:0] frame;
    initial begin
        line = 1'b1;
        busy = 1'b0;
        // stop, sync byte, start: shifted out from bit 0
        frame = {1'b1, baud_pkg::SYNC_CHAR, 1'b0};
        forever begin
            do @(posedge clk_sys); while (go !== 1'b1);
            busy <= 1'b1;
            if (with_break) begin
                line <= 1'b0;
                repeat (13 * bit_cycles) @(posedge clk_sys);
                line <= 1'b1;
                repeat (2 * bit_cycles) @(posedge clk_sys);
            end
            for (int i = 0; i < 10; i++) begin
                line <= frame[i];
                repeat (bit_cycles) @(posedge clk_sys);
            end
            busy <= 1'b0;
        end
    end
endmodule : sync_node
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the baud generator with auto-baud measurement
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, rx_level, baud_tick, serial_hold, receive_flag;
    logic tx_load, node_line, node_busy, rx_pin;
    logic [7:0] tx_data;
    logic go = 1'b0;
    logic with_break = 1'b0;
    logic glitch = 1'b0;
    logic [15:0] bit_cycles = 16'h0140;
    int num_errors = 0;
    int samples_checked = 0;
    int tx_loads = 0;
    logic [31:0] rd;
    int ms[6] = '{0, 0, 0, 0, 1, 1};
    int mw[6] = '{0, 0, 1, 1, 0, 1};
    int mh[6] = '{0, 1, 0, 1, 1, 0};
    // prescale times divisor plus one: 3 for the low byte, 259 for the pair
    int mp[6] = '{192, 48, 4144, 1036, 12, 1036};
    int aw[3] = '{0, 0, 1};
    int ah[3] = '{0, 1, 1};
    int ak[3] = '{0, 1, 0};
    int at[3] = '{640, 320, 320};
    int ae[3] = '{10, 20, 80};

    always #5 clk_sys = ~clk_sys;
    // glitch pulls the line low on top of the node
    assign rx_pin = node_line & ~glitch;
    always @(posedge clk_sys) if (tx_load === 1'b1) tx_loads <= tx_loads + 1;

    baud_generator_autobaud u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_pin(rx_pin), .rx_level(rx_level), .baud_tick(baud_tick),
        .serial_hold(serial_hold), .receive_flag(receive_flag),
        .tx_data(tx_data), .tx_load(tx_load));

    sync_node u_node (.clk_sys(clk_sys), .go(go), .with_break(with_break),
        .bit_cycles(bit_cycles), .line(node_line), .busy(node_busy));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic fail(input string w);
        num_errors++;
        $display("mismatch at %0t: %s", $time, w);
    endtask : fail
    task automatic hang(input string w);
        fail(w);
        report_and_stop();
    endtask : hang
    task automatic check_eq(input logic [31:0] g, e, input string w);
        samples_checked++;
        if (g !== e) fail($sformatf("%s got %h want %h", w, g, e));
    endtask : check_eq
    task automatic check_in(input logic [31:0] g, lo, hi, input string w);
        samples_checked++;
        if ((g >= lo && g <= hi) !== 1'b1) fail($sformatf("%s got %h", w, g));
    endtask : check_in
    // holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= ~wr;
        avs_write <= wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) hang("bus timeout");
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic rchk(input logic [4:0] a, input logic [31:0] e, string w);
        bus(1'b0, a, 8'h00);
        check_eq(rd, e, w);
    endtask : rchk
    task automatic count_tick(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (baud_tick !== 1'b1 && n < 20000);
        if (baud_tick !== 1'b1) hang("no tick");
    endtask : count_tick
    task automatic send(input logic brk, input logic [15:0] t);
        @(posedge clk_sys);
        with_break <= brk;
        bit_cycles <= t;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
    endtask : send
    task automatic wait_node;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (node_busy !== 1'b0 && n < 60000);
        if (node_busy !== 1'b0) hang("frame timeout");
        repeat (4) @(posedge clk_sys);
    endtask : wait_node

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        int n;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        rchk(baud_pkg::OFS_BAUD, 32'h40, "baud reset");
        rchk(baud_pkg::OFS_DIV_HI, 32'h0, "div reset");
        rchk(5'h03, 32'h0, "unmapped");
        bus(1'b1, baud_pkg::OFS_RSC, 8'hFF);
        rchk(baud_pkg::OFS_RSC, 32'hF8, "rsc mask");
        glitch <= 1'b1;
        @(posedge clk_sys);
        glitch <= 1'b0;
        repeat (6) begin
            @(posedge clk_sys);
            check_eq(rx_level, 32'h1, "one low sample");
        end
        glitch <= 1'b1;
        repeat (8) @(posedge clk_sys);
        check_eq(rx_level, 32'h0, "low level");
        glitch <= 1'b0;
        // inverted polarity turns the idle-high line into a low level
        bus(1'b1, baud_pkg::OFS_BAUD, 8'h20);
        repeat (5) @(posedge clk_sys);
        check_eq(rx_level, 32'h0, "inverted idle");
        rchk(baud_pkg::OFS_BAUD, 32'h60, "invert bit");
        bus(1'b1, baud_pkg::OFS_BAUD, 8'h00);
        bus(1'b1, baud_pkg::OFS_DIV_LO, 8'h02);
        bus(1'b1, baud_pkg::OFS_DIV_HI, 8'h01);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, baud_pkg::OFS_TSC, 8'(16 * ms[i] + 4 * mh[i]));
            bus(1'b1, baud_pkg::OFS_BAUD, 8'(8 * mw[i]));
            // tick to tick, so the phase left by the mode change drops out
            count_tick(n);
            count_tick(n);
            check_eq(n, mp[i], "period");
        end
        bus(1'b1, baud_pkg::OFS_DIV_LO, 8'h05);
        count_tick(n);
        check_in(n, 1046, 1050, "restart");
        bus(1'b1, baud_pkg::OFS_TSC, 8'h00);
        bus(1'b1, baud_pkg::OFS_TXBUF, 8'hA5);
        repeat (3) @(posedge clk_sys);
        check_eq(tx_loads, 1, "tx load");
        check_eq({24'h0, tx_data}, 32'hA5, "tx data");
        bus(1'b1, baud_pkg::OFS_BAUD, 8'h80);
        rchk(baud_pkg::OFS_BAUD, 32'hC0, "ovf set");
        bus(1'b1, baud_pkg::OFS_BAUD, 8'h00);
        rchk(baud_pkg::OFS_BAUD, 32'h40, "ovf clear");
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, baud_pkg::OFS_TSC, 8'(4 * ah[i]));
            bus(1'b1, baud_pkg::OFS_DIV_LO, 8'h33);
            bus(1'b1, baud_pkg::OFS_BAUD, 8'(8 * aw[i] + 2 * ak[i] + 1));
            rchk(baud_pkg::OFS_DIV_LO, 32'h0, "cleared");
            bus(1'b1, baud_pkg::OFS_TXBUF, 8'h5A);
            send(ak[i][0], 16'(at[i]));
            repeat (3 * at[i]) @(posedge clk_sys);
            check_eq(serial_hold, 32'h1, "hold");
            wait_node();
            check_eq(tx_loads, 1, "tx refused");
            check_eq(receive_flag, 32'h1, "flag set");
            rchk(baud_pkg::OFS_BAUD, 8'(8 * aw[i] + 64), "done");
            check_eq({24'h0, tx_data}, 32'hA5, "tx kept");
            bus(1'b0, baud_pkg::OFS_DIV_LO, 8'h00);
            check_in(rd, ae[i] - 1, ae[i], "measured");
            rchk(baud_pkg::OFS_DIV_HI, 32'h0, "high byte");
            bus(1'b0, baud_pkg::OFS_RXBUF, 8'h00);
            repeat (2) @(posedge clk_sys);
            check_eq(receive_flag, 32'h0, "flag clear");
        end
        bus(1'b1, baud_pkg::OFS_TSC, 8'h10);
        bus(1'b1, baud_pkg::OFS_BAUD, 8'h01);
        send(1'b0, 16'h0140);
        wait_node();
        check_eq(receive_flag, 32'h0, "sync flag");
        check_eq(serial_hold, 32'h0, "sync hold");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
